// ---- stc_top.sv ----
// serial threshold comparator: serial load, mode decode and output compare
// assumes serial clock, data and mode pins are asynchronous, sampled here
`timescale 1ns/1ps
module stc_top import stc_pkg::*; (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // serial link pins
  input wire logic serial_clk_i,
  input wire logic serial_data_i,
  // mode select pins
  input wire logic mode_select_low_i,
  input wire logic mode_select_high_i,
  // analog comparator result: sample above threshold reference
  input wire logic sample_above_i,
  // threshold to the reference converter
  output logic [7:0] comparator_threshold_o,
  // analog path controls
  output logic press_power_o,
  output logic temp_power_o,
  output logic temp_current_o,
  output logic press_mux_o,
  output logic temp_mux_o,
  output logic comp_enable_o,
  // output pin
  output logic out_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic sclk_s;
  logic sdata_s;
  logic msl_s;
  logic msh_s;

  stc_sync u_sync_clk (.clock_i(clock_i), .reset_i(reset_i), .pin_i(serial_clk_i),
    .level_o(sclk_s));
  stc_sync u_sync_dat (.clock_i(clock_i), .reset_i(reset_i), .pin_i(serial_data_i),
    .level_o(sdata_s));
  stc_sync u_sync_msl (.clock_i(clock_i), .reset_i(reset_i), .pin_i(mode_select_low_i),
    .level_o(msl_s));
  stc_sync u_sync_msh (.clock_i(clock_i), .reset_i(reset_i), .pin_i(mode_select_high_i),
    .level_o(msh_s));

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  function automatic stc_mode_type stc_decode(input logic hi, input logic lo);
    stc_mode_type m;
    m = STC_STANDBY;
    if (hi && lo) begin
      m = STC_OUT_READ;
    end else if (hi) begin
      m = STC_MEAS_TEMP;
    end else if (lo) begin
      m = STC_MEAS_PRESS;
    end
    return m;
  endfunction

  stc_mode_type mode_q;
  stc_mode_type mode_d;
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [3:0] count_q;
  logic [3:0] count_d;
  logic [7:0] thr_q;
  logic [7:0] thr_d;
  logic rise;
  logic fall;
  logic measuring;

  assign rise = sclk_s && !sclk_prev_q;
  assign fall = !sclk_s && sclk_prev_q;
  assign measuring = (mode_q == STC_MEAS_PRESS) || (mode_q == STC_MEAS_TEMP);

  // ----------------------------------------
  // serial load
  // ----------------------------------------
  // next values of the shift path, counter and threshold
  always_comb begin
    mode_d = stc_decode(msh_s, msl_s);
    sclk_prev_d = sclk_s;
    shift_d = shift_q;
    count_d = count_q;
    thr_d = thr_q; // held unless a burst completes outside measure modes
    if (rise) begin
      shift_d = {shift_q[6:0], sdata_s}; // msb first
    end
    if (measuring) begin
      count_d = STC_CNT_RESET;
    end else if (fall) begin
      if (count_q == STC_BITS_PER_LOAD - 4'h1) begin
        thr_d = shift_q; // bit7 weight 128
        count_d = STC_CNT_RESET;
      end else begin
        count_d = count_q + 4'h1;
      end
    end
  end

  // registers; reset stands in for power up, which is undefined
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mode_q <= STC_STANDBY;
      sclk_prev_q <= 1'b0;
      shift_q <= STC_THR_RESET;
      count_q <= STC_CNT_RESET;
      thr_q <= STC_THR_RESET;
    end else begin
      mode_q <= mode_d;
      sclk_prev_q <= sclk_prev_d;
      shift_q <= shift_d;
      count_q <= count_d;
      thr_q <= thr_d;
    end
  end

  // ----------------------------------------
  // analog path sequencing
  // ----------------------------------------
  logic press_pwr_q, press_pwr_d, temp_pwr_q, temp_pwr_d;
  logic press_mux_q, press_mux_d, temp_mux_q, temp_mux_d;
  logic comp_q, comp_d, out_q, out_d;
  logic temp_cur_q;
  logic temp_cur_d;
  logic [3:0] hold_q;
  logic [3:0] hold_d;

  // mux follows mode at once; power lingers until isolate time ends on exit to standby or read
  always_comb begin
    press_mux_d = (mode_d == STC_MEAS_PRESS);
    temp_mux_d = (mode_d == STC_MEAS_TEMP);
    comp_d = (mode_d == STC_OUT_READ);
    hold_d = hold_q;
    press_pwr_d = press_pwr_q;
    temp_pwr_d = temp_pwr_q;
    if (press_mux_d || temp_mux_d) begin
      press_pwr_d = press_mux_d;
      temp_pwr_d = temp_mux_d;
      hold_d = STC_ISOLATE_CYC;
    end else if (hold_q != 4'h0) begin
      hold_d = hold_q - 4'h1;
    end else begin
      press_pwr_d = 1'b0;
      temp_pwr_d = 1'b0;
    end
    // excitation only with temp power and temp mux both on
    temp_cur_d = temp_pwr_d && temp_mux_d;
    // compare against stored threshold reference
    out_d = comp_q ? sample_above_i : 1'b1;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      press_pwr_q <= 1'b0;
      temp_pwr_q <= 1'b0;
      press_mux_q <= 1'b0;
      temp_mux_q <= 1'b0;
      comp_q <= 1'b0;
      out_q <= 1'b1;
      temp_cur_q <= 1'b0;
      hold_q <= 4'h0;
    end else begin
      press_pwr_q <= press_pwr_d;
      temp_pwr_q <= temp_pwr_d;
      press_mux_q <= press_mux_d;
      temp_mux_q <= temp_mux_d;
      comp_q <= comp_d;
      out_q <= out_d;
      temp_cur_q <= temp_cur_d;
      hold_q <= hold_d;
    end
  end

  assign comparator_threshold_o = thr_q;
  assign press_power_o = press_pwr_q;
  assign temp_power_o = temp_pwr_q;
  assign temp_current_o = temp_cur_q;
  assign press_mux_o = press_mux_q;
  assign temp_mux_o = temp_mux_q;
  assign comp_enable_o = comp_q;
  assign out_o = out_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_count_clear: assert property (@(posedge clock_i) disable iff (reset_i)
    measuring |=> count_q == STC_CNT_RESET) else $error("counter not cleared");
  chk_shift_msb: assert property (@(posedge clock_i) disable iff (reset_i)
    rise |=> shift_q[0] == $past(sdata_s) && shift_q[7:1] == $past(shift_q[6:0]))
    else $error("shift wrong");
  chk_thr_load: assert property (@(posedge clock_i) disable iff (reset_i)
    (fall && !measuring && count_q == 4'h7) |=> thr_q == $past(shift_q))
    else $error("threshold not loaded");
  chk_thr_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    !(fall && count_q == 4'h7) |=> $stable(thr_q)) else $error("threshold changed");
  chk_temp_current: assert property (@(posedge clock_i) disable iff (reset_i)
    temp_current_o |-> temp_mux_q) else $error("current outside temp mode");
  chk_mux_first: assert property (@(posedge clock_i) disable iff (reset_i)
    $fell(press_mux_q) |-> press_pwr_q) else $error("power dropped before isolate");
  chk_temp_isolate: assert property (@(posedge clock_i) disable iff (reset_i)
    $fell(temp_mux_q) |-> temp_pwr_q[*2]) else $error("temp power dropped early");
  chk_out_follow: assert property (@(posedge clock_i) disable iff (reset_i)
    comp_q |=> out_q == $past(sample_above_i)) else $error("out not comparing");
  chk_read_mode: assert property (@(posedge clock_i) disable iff (reset_i)
    (msh_s && msl_s) |=> comp_q) else $error("comparator not enabled");
  cov_load: cover property (@(posedge clock_i) fall && count_q == 4'h7 && !measuring);
  cov_press: cover property (@(posedge clock_i) $fell(press_mux_q));
  cov_temp: cover property (@(posedge clock_i) $fell(temp_mux_q));
  cov_read: cover property (@(posedge clock_i) comp_q && out_q == 1'b0);
endmodule

// ---- stc_pkg.sv ----
// package for the serial threshold comparator readout block
// assumes a 40 MHz system clock sampling slow external serial pins
package stc_pkg;
  // ----------------------------------------
  // widths and counts
  // ----------------------------------------
  localparam int STC_THR_W = 8;
  localparam logic [3:0] STC_BITS_PER_LOAD = 4'h8;
  localparam logic [3:0] STC_CNT_RESET = 4'h0;
  localparam logic [7:0] STC_THR_RESET = 8'h00;
  localparam logic [7:0] STC_THR_MSB_WEIGHT = 8'h80;
  // settle cycles from mux open to path power down on measure exit
  localparam int STC_ISOLATE_NS = 100;
  localparam int STC_CLK_NS = 25;
  localparam logic [3:0] STC_ISOLATE_CYC = 4'((STC_ISOLATE_NS + STC_CLK_NS - 1) / STC_CLK_NS);

  // ----------------------------------------
  // operating modes, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    STC_STANDBY = 4'h1,
    STC_MEAS_PRESS = 4'h2,
    STC_MEAS_TEMP = 4'h4,
    STC_OUT_READ = 4'h8
  } stc_mode_type;
endpackage

// ---- stc_sync.sv ----
// two flip-flop synchroniser for one external pin
// assumes the input is asynchronous to clock_i
`timescale 1ns/1ps
module stc_sync (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // pin in, synchronised level out
  input wire logic pin_i,
  output logic level_o
);
  logic meta_q;
  logic meta_d;
  logic level_q;
  logic level_d;

  // next values
  always_comb begin
    meta_d = pin_i;
    level_d = meta_q;
  end

  // two stages, reset to low as an open pin reads low
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      meta_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;
endmodule

// ---- stc_mcu_model.sv ----
// controller model: drives serial clock, data and mode pins of the block
// assumes tasks are started on a falling edge of the 25 ns system clock
`timescale 1ns/1ps
module stc_mcu_model (
  // serial link pins
  output logic serial_clk_o,
  output logic serial_data_o,
  // mode select pins
  output logic mode_select_low_o,
  output logic mode_select_high_o
);
  // idle pins low, as the pull-downs would leave them
  initial begin
    serial_clk_o = 1'b0;
    serial_data_o = 1'b0;
    mode_select_low_o = 1'b0;
    mode_select_high_o = 1'b0;
  end

  // n bits, msb first, 200 ns clock; only called in standby or read
  task automatic send_bits(input logic [7:0] val, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      serial_data_o = val[i];
      #100 serial_clk_o = 1'b1;
      #100 serial_clk_o = 1'b0;
    end
    serial_data_o = 1'b0; // released to pull-down level
    #100;
  endtask

  // set both mode pins and let them settle
  task automatic set_mode(input logic hi, input logic lo);
    mode_select_high_o = hi;
    mode_select_low_o = lo;
    #500;
  endtask

  // pulse one mode pin to resync the bit counter
  task automatic pulse_mode(input logic hi);
    set_mode(hi, !hi);
    set_mode(1'b0, 1'b0);
  endtask
endmodule

// ---- tb_top.sv ----
// testbench for the serial threshold comparator
// assumes stc_top, stc_pkg and stc_mcu_model are compiled before it
`timescale 1ns/1ps
module tb_top;
  import stc_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic sample_above_i = 1'b0;
  logic [7:0] level = 8'h00;
  logic s_clk, s_dat, m_lo, m_hi;
  logic [7:0] thr;
  logic pp, tp, tc, pm, tm, ce, out;
  int n_errors = 0;
  int n_tests = 0;

  // ----------------------------------------
  // clock, analog sample model, instances
  // ----------------------------------------
  always #12.5 clock_i = ~clock_i;
  always @(negedge clock_i) sample_above_i <= ((level >= thr) === 1'b1);

  stc_mcu_model i_mcu (.serial_clk_o(s_clk), .serial_data_o(s_dat),
    .mode_select_low_o(m_lo), .mode_select_high_o(m_hi));
  stc_top i_dut (.clock_i(clock_i), .reset_i(reset_i), .serial_clk_i(s_clk),
    .serial_data_i(s_dat), .mode_select_low_i(m_lo), .mode_select_high_i(m_hi),
    .sample_above_i(sample_above_i), .comparator_threshold_o(thr),
    .press_power_o(pp), .temp_power_o(tp), .temp_current_o(tc), .press_mux_o(pm),
    .temp_mux_o(tm), .comp_enable_o(ce), .out_o(out));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic load(input logic [7:0] v);
    i_mcu.send_bits(v, 8);
    cyc(4);
  endtask

  task automatic complete_run;
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_load;
    logic [7:0] tbl [4] = '{8'hA5, 8'h3C, 8'h80, 8'h01};
    foreach (tbl[i]) begin
      load(tbl[i]);
      check(thr, tbl[i]);
    end
    i_mcu.send_bits(8'hFF, 7);
    cyc(4);
    check(thr, 8'h01);
    // one more bit completes the partial burst: seven ones then a zero
    i_mcu.send_bits(8'h00, 1);
    cyc(4);
    check(thr, 8'hFE);
    load(8'hFF);
    check(thr, 8'hFF);
  endtask

  task automatic t_resync;
    for (int p = 0; p < 2; p++) begin
      i_mcu.send_bits(8'h00, 3);
      i_mcu.pulse_mode(p[0]);
      check(thr, p ? 8'h5A : 8'hFF);
      load(p ? 8'hC3 : 8'h5A);
      check(thr, p ? 8'hC3 : 8'h5A);
    end
  endtask

  task automatic t_modes;
    for (int p = 0; p < 2; p++) begin
      i_mcu.set_mode(p[0], !p[0]);
      check({pp, pm, tp, tm, tc, ce}, p ? 8'h0E : 8'h30);
      check(thr, 8'hC3);
      i_mcu.mode_select_high_o = 1'b0;
      i_mcu.mode_select_low_o = 1'b0;
      cyc(5);
      check({pp, pm, tp, tm}, p ? 8'h02 : 8'h08);
      cyc(15);
      check({pp, pm, tp, tm, tc, ce}, 8'h00);
    end
  endtask

  // successive approximation in output read, well inside hold time
  task automatic t_read;
    logic [7:0] res = 8'h00;
    i_mcu.set_mode(1'b1, 1'b1);
    check(ce, 8'h01);
    level = 8'h6B;
    for (int b = 7; b >= 0; b--) begin
      load(res | (8'h01 << b));
      check(out, ((res | (8'h01 << b)) <= 8'h6B));
      if (out === 1'b1) res = res | (8'h01 << b);
    end
    check(res, 8'h6B);
    load(8'h00);
    check(thr, 8'h00);
    level = 8'h00;
    i_mcu.set_mode(1'b0, 1'b0);
    check({ce, out}, 8'h01);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    cyc(12);
    reset_i = 1'b0;
    cyc(3);
    check({thr, out}, 9'h001);
    t_load();
    t_resync();
    t_modes();
    t_read();
    complete_run();
  end

  initial begin
    #300000;
    n_errors++;
    complete_run();
  end
endmodule
